// ===== hdl/bert_rx_pkg.sv
package bert_rx_pkg;

    // ------------------------------------------------------------------
    // Widths
    // ------------------------------------------------------------------
    localparam int CNT_W  = 32;
    localparam int REG_W  = 16;
    localparam int ADDR_W = 10;
    localparam int LEN_W  = 5;

    // ------------------------------------------------------------------
    // Register offsets (byte addresses of the register port)
    // ------------------------------------------------------------------
    localparam logic [ADDR_W-1:0] BIT_COUNT_LOW_OFS     = 10'h2B4;
    localparam logic [ADDR_W-1:0] BIT_COUNT_HIGH_OFS    = 10'h2B8;
    localparam logic [ADDR_W-1:0] ERROR_COUNT_LOW_OFS   = 10'h2BC;
    localparam logic [ADDR_W-1:0] ERROR_COUNT_HIGH_OFS  = 10'h2C0;
    localparam logic [ADDR_W-1:0] PATTERN_CAPT_LOW_OFS  = 10'h2C4;
    localparam logic [ADDR_W-1:0] PATTERN_CAPT_HIGH_OFS = 10'h2C8;

    // ------------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------------
    localparam logic [REG_W-1:0] RESULT_RESET  = 16'h0000;
    localparam logic [CNT_W-1:0] COUNTER_RESET = 32'h0000_0000;

    // ------------------------------------------------------------------
    // Carriers
    // ------------------------------------------------------------------
    typedef struct packed {
        logic              rd;
        logic [ADDR_W-1:0] addr;
    } reg_req_t;

    typedef struct packed {
        logic enable;   // Test receiver enabled
        logic sync;     // Test receiver synchronized
        logic slot;     // One receive clock slot
        logic bitErr;   // Bit error detected in this slot
        logic dataBit;  // Received data bit of this slot
    } rx_line_t;

endpackage

// ===== hdl/counter_snapshot.sv
`timescale 1ns/1ps
`default_nettype none

module counter_snapshot #(
    parameter int W = 32
) (
    input  wire logic         clk,
    input  wire logic         rst,
    input  wire logic         incr,
    input  wire logic         transfer,
    output var  logic [W-1:0] running,
    output var  logic [W-1:0] held
);

    logic [W-1:0] running_d;

    // ------------------------------------------------------------------
    // Background counter
    // ------------------------------------------------------------------
    // On transfer the event of that same cycle starts the new interval,
    // so no increment is ever lost across a snapshot.
    always_comb begin
        if (transfer) begin
            running_d = {{(W-1){1'b0}}, incr};
        end else begin
            running_d = running + {{(W-1){1'b0}}, incr};
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            running <= '0;
        end else begin
            running <= running_d;
        end
    end

    // Foreground copy, both halves from one snapshot
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            held <= '0;
        end else if (transfer) begin
            held <= running;
        end
    end

    // ------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------
    property p_countStep;
        @(posedge clk) disable iff (rst)
        incr && !transfer |=> running == $past(running) + 1'b1;
    endproperty
    a_countStep: assert property (p_countStep) else $error("count step wrong");

    property p_snapshot;
        @(posedge clk) disable iff (rst)
        transfer |=> (held == $past(running)) && (running == W'($past(incr)));
    endproperty
    a_snapshot: assert property (p_snapshot) else $error("snapshot wrong");

endmodule

`default_nettype wire

// ===== hdl/bert_receive_counters.sv
`timescale 1ns/1ps
`default_nettype none

module bert_receive_counters #(
    parameter int CNT_W = bert_rx_pkg::CNT_W
) (
    input  wire logic                           clk,
    input  wire logic                           rst,
    input  wire bert_rx_pkg::reg_req_t          regReq,
    output var  logic [bert_rx_pkg::REG_W-1:0]  regRdData,
    input  wire bert_rx_pkg::rx_line_t          rxLine,
    input  wire logic                           intervalEnd,
    input  wire logic                           captureResultsCmd,
    input  wire logic                           capturePatternCmd,
    input  wire logic                           clearAutoMask,
    input  wire logic                           fixedPatternModeSel,
    input  wire logic [bert_rx_pkg::LEN_W-1:0]  patternLengthField,
    input  wire logic [CNT_W-1:0]               generatorState,
    input  wire logic                           bitErrIntEn,
    input  wire logic                           endMeasIntEn,
    output var  logic                           intervalDoneFlag,
    output var  logic                           bitErrIrq,
    output var  logic                           endMeasIrq
);

    // ------------------------------------------------------------------
    // Events
    // ------------------------------------------------------------------
    logic             slotIncr;
    logic             errIncr;
    logic             transfer;
    logic             errRead;
    logic [CNT_W-1:0] bitSlotRunning;
    logic [CNT_W-1:0] bitSlotCount;
    logic [CNT_W-1:0] errorRunning;
    logic [CNT_W-1:0] errorTally;
    logic             autoMask_q;
    logic [CNT_W-1:0] rawSample_q;
    logic [CNT_W-1:0] capturedPattern_q;
    logic [CNT_W-1:0] lengthMask;
    logic [bert_rx_pkg::REG_W-1:0] rdData_d;

    // Gated counting conditions
    assign slotIncr = rxLine.enable && rxLine.slot;
    assign errIncr  = rxLine.enable && rxLine.sync && rxLine.bitErr;

    // Command always moves results; interval end waits for the last read
    assign transfer = captureResultsCmd || (intervalEnd && !intervalDoneFlag);

    assign errRead = regReq.rd &&
                     ((regReq.addr == bert_rx_pkg::ERROR_COUNT_LOW_OFS) ||
                      (regReq.addr == bert_rx_pkg::ERROR_COUNT_HIGH_OFS));

    // ------------------------------------------------------------------
    // Counters
    // ------------------------------------------------------------------
    counter_snapshot #(
        .W (CNT_W)
    ) u_bitSlot (
        .clk      (clk),
        .rst      (rst),
        .incr     (slotIncr),
        .transfer (transfer),
        .running  (bitSlotRunning),
        .held     (bitSlotCount)
    );

    counter_snapshot #(
        .W (CNT_W)
    ) u_errorTally (
        .clk      (clk),
        .rst      (rst),
        .incr     (errIncr),
        .transfer (transfer),
        .running  (errorRunning),
        .held     (errorTally)
    );

    // ------------------------------------------------------------------
    // End-of-measurement flag and interrupts
    // ------------------------------------------------------------------
    // Set wins over the read clear so a result is never silently lost
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            intervalDoneFlag <= 1'b0;
        end else if (transfer) begin
            intervalDoneFlag <= 1'b1;
        end else if (errRead) begin
            intervalDoneFlag <= 1'b0;
        end
    end

    // End-of-measurement pulse follows every transfer when enabled
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            endMeasIrq <= 1'b0;
        end else begin
            endMeasIrq <= transfer && endMeasIntEn;
        end
    end

    // Auto mask keeps an error burst from flooding the host; set wins over clear
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            autoMask_q <= 1'b0;
        end else if (errIncr && bitErrIntEn) begin
            autoMask_q <= 1'b1;
        end else if (clearAutoMask) begin
            autoMask_q <= 1'b0;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            bitErrIrq <= 1'b0;
        end else begin
            bitErrIrq <= errIncr && bitErrIntEn && !autoMask_q;
        end
    end

    // ------------------------------------------------------------------
    // Fixed pattern capture
    // ------------------------------------------------------------------
    // Raw sample, newest bit in position 0
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            rawSample_q <= bert_rx_pkg::COUNTER_RESET;
        end else if (rxLine.slot) begin
            rawSample_q <= {rawSample_q[CNT_W-2:0], rxLine.dataBit};
        end
    end

    // Keeps bits 0..length; bits above carry no pattern
    always_comb begin
        for (int i = 0; i < CNT_W; i++) begin
            lengthMask[i] = (i <= int'(patternLengthField));
        end
    end

    // Capture is meaningful only in fixed-pattern mode
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            capturedPattern_q <= bert_rx_pkg::COUNTER_RESET;
        end else if (capturePatternCmd && fixedPatternModeSel) begin
            if (rxLine.sync) begin
                capturedPattern_q <= generatorState & lengthMask;
            end else begin
                capturedPattern_q <= rawSample_q;
            end
        end
    end

    // ------------------------------------------------------------------
    // Register read port
    // ------------------------------------------------------------------
    always_comb begin
        case (regReq.addr)
            bert_rx_pkg::BIT_COUNT_LOW_OFS:     rdData_d = bitSlotCount[15:0];
            bert_rx_pkg::BIT_COUNT_HIGH_OFS:    rdData_d = bitSlotCount[31:16];
            bert_rx_pkg::ERROR_COUNT_LOW_OFS:   rdData_d = errorTally[15:0];
            bert_rx_pkg::ERROR_COUNT_HIGH_OFS:  rdData_d = errorTally[31:16];
            bert_rx_pkg::PATTERN_CAPT_LOW_OFS:  rdData_d = capturedPattern_q[15:0];
            bert_rx_pkg::PATTERN_CAPT_HIGH_OFS: rdData_d = capturedPattern_q[31:16];
            default:                            rdData_d = bert_rx_pkg::RESULT_RESET;
        endcase
    end

    // Read data held until the next read
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            regRdData <= bert_rx_pkg::RESULT_RESET;
        end else if (regReq.rd) begin
            regRdData <= rdData_d;
        end
    end

    // ------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------
    property p_readBitHigh;
        @(posedge clk) disable iff (rst)
        regReq.rd && regReq.addr == bert_rx_pkg::BIT_COUNT_HIGH_OFS
        |=> regRdData == $past(bitSlotCount[31:16]);
    endproperty
    a_readBitHigh: assert property (p_readBitHigh) else $error("bit count high word");

    property p_noSlotWhenOff;
        @(posedge clk) disable iff (rst)
        !rxLine.enable && !transfer |=> $stable(bitSlotRunning);
    endproperty
    a_noSlotWhenOff: assert property (p_noSlotWhenOff) else $error("slot counted while off");

    property p_captureMoves;
        @(posedge clk) disable iff (rst)
        captureResultsCmd |=> intervalDoneFlag && errorTally == $past(errorRunning)
                              && bitSlotCount == $past(bitSlotRunning);
    endproperty
    a_captureMoves: assert property (p_captureMoves) else $error("capture lost");

    property p_noErrUnsync;
        @(posedge clk) disable iff (rst)
        !rxLine.sync && !transfer |=> $stable(errorRunning);
    endproperty
    a_noErrUnsync: assert property (p_noErrUnsync) else $error("error counted unsynced");

    property p_irqOnce;
        @(posedge clk) disable iff (rst)
        bitErrIrq && !clearAutoMask ##1 errIncr && bitErrIntEn |=> !bitErrIrq;
    endproperty
    a_irqOnce: assert property (p_irqOnce) else $error("bit error irq repeated");

    property p_holdWhileFlag;
        @(posedge clk) disable iff (rst)
        intervalDoneFlag && !captureResultsCmd |=> $stable(errorTally) && $stable(bitSlotCount);
    endproperty
    a_holdWhileFlag: assert property (p_holdWhileFlag) else $error("result overwritten");

    property p_endIrq;
        @(posedge clk) disable iff (rst)
        intervalEnd && !intervalDoneFlag && endMeasIntEn |=> endMeasIrq ##1 !endMeasIrq || $past(transfer);
    endproperty
    a_endIrq: assert property (p_endIrq) else $error("end irq missing");

    property p_rawCapture;
        @(posedge clk) disable iff (rst)
        capturePatternCmd && fixedPatternModeSel && !rxLine.sync
        |=> capturedPattern_q == $past(rawSample_q);
    endproperty
    a_rawCapture: assert property (p_rawCapture) else $error("raw sample not stored");

    property p_readClears;
        @(posedge clk) disable iff (rst)
        errRead && !transfer |=> !intervalDoneFlag;
    endproperty
    a_readClears: assert property (p_readClears) else $error("flag not cleared");

    property p_intervalSets;
        @(posedge clk) disable iff (rst)
        intervalEnd && !(errRead && intervalDoneFlag) |=> intervalDoneFlag;
    endproperty
    a_intervalSets: assert property (p_intervalSets) else $error("flag not set");

endmodule

`default_nettype wire

// ===== dv/host_reader.sv
`timescale 1ns/1ps
`default_nettype none

// ----------------------------------------------------------------------
// Host model: register reads only, all results are read-only
// ----------------------------------------------------------------------
module host_reader (
    input  wire logic                          clk,
    input  wire logic [bert_rx_pkg::REG_W-1:0] rdData,
    output var  bert_rx_pkg::reg_req_t         regReq
);
    initial regReq = '0;

    // Request held up to the taking edge; idle address is inverted so stale never matches
    task automatic read(input  logic [bert_rx_pkg::ADDR_W-1:0] a,
                        output logic [bert_rx_pkg::REG_W-1:0]  d);
        @(posedge clk);
        regReq <= '{rd: 1'b1, addr: a};
        @(posedge clk);
        regReq <= '{rd: 1'b0, addr: ~a};
        @(posedge clk);
        d = rdData;
    endtask
endmodule

`default_nettype wire

// ===== dv/tb_bert_receive_counters.sv
`timescale 1ns/1ps
`default_nettype none

module tb_bert_receive_counters;
    // ------------------------------------------------------------------
    // Signals
    // ------------------------------------------------------------------
    logic                  clk = 1'b0;
    logic                  rst = 1'b1;
    bert_rx_pkg::reg_req_t regReq;
    logic [15:0]           rdData;
    bert_rx_pkg::rx_line_t rx = '0;
    logic [3:0]            cmd = '0;
    logic                  fixMode = 1'b0, bie = 1'b0, eie = 1'b0;
    logic [4:0]            patLen = '0;
    logic [31:0]           gen = '0;
    logic                  flag, bIrq, eIrq;
    logic [31:0]           eBitBg, eBitFg, eErrBg, eErrFg, ePat, eShift;
    logic                  eFlag, eEnd, eBIrq, eMask;
    integer                seed = 58533;
    int                    n_errors = 0;
    int                    checks = 0;

    always #4 clk = ~clk;

    host_reader host (.clk(clk), .rdData(rdData), .regReq(regReq));

    bert_receive_counters dut (
        .clk(clk), .rst(rst), .regReq(regReq), .regRdData(rdData), .rxLine(rx),
        .intervalEnd(cmd[0]), .captureResultsCmd(cmd[1]), .capturePatternCmd(cmd[2]),
        .clearAutoMask(cmd[3]), .fixedPatternModeSel(fixMode), .patternLengthField(patLen),
        .generatorState(gen), .bitErrIntEn(bie), .endMeasIntEn(eie),
        .intervalDoneFlag(flag), .bitErrIrq(bIrq), .endMeasIrq(eIrq));

    // ------------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------------
    task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
        checks++;
        if (got !== exp) begin
            n_errors++;
            $display("[FAIL] %s expected %h seen %h", name, exp, got);
        end
    endtask

    task automatic test_done();
        if (n_errors == 0 && checks > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask

    function automatic logic [31:0] keepMask(input logic [4:0] l);
        logic [32:0] m;
        m = (33'h1 << (l + 6'h01)) - 33'h1;
        return m[31:0];
    endfunction

    // Expected behaviour mirror; outputs compared each cycle before this edge lands
    always @(posedge clk or posedge rst) begin
        logic bi, ei, xfer, rdErr;
        if (rst) begin
            {eBitBg, eBitFg, eErrBg, eErrFg, ePat, eShift} <= '0;
            {eFlag, eEnd, eBIrq, eMask} <= '0;
        end else begin
            chk("intervalDoneFlag", {31'h0, eFlag}, {31'h0, flag});
            chk("endMeasIrq", {31'h0, eEnd}, {31'h0, eIrq});
            chk("bitErrIrq", {31'h0, eBIrq}, {31'h0, bIrq});
            bi = rx.enable & rx.slot;
            ei = rx.enable & rx.sync & rx.bitErr;
            xfer = cmd[1] | (cmd[0] & ~eFlag);
            rdErr = regReq.rd & (regReq.addr == bert_rx_pkg::ERROR_COUNT_LOW_OFS
                                 || regReq.addr == bert_rx_pkg::ERROR_COUNT_HIGH_OFS);
            if (xfer) begin
                eBitFg <= eBitBg;
                eErrFg <= eErrBg;
                eBitBg <= {31'h0, bi};
                eErrBg <= {31'h0, ei};
            end else begin
                eBitBg <= eBitBg + {31'h0, bi};
                eErrBg <= eErrBg + {31'h0, ei};
            end
            eFlag <= xfer | (eFlag & ~rdErr);
            eEnd <= xfer & eie;
            eBIrq <= ei & bie & ~eMask;
            eMask <= (ei & bie) | (eMask & ~cmd[3]);
            if (rx.slot) eShift <= {eShift[30:0], rx.dataBit};
            if (cmd[2] & fixMode) ePat <= rx.sync ? (gen & keepMask(patLen)) : eShift;
        end
    end

    // Random line traffic, one slot per cycle at most
    task automatic traffic(input int n);
        logic [31:0] r;
        repeat (n) begin
            @(posedge clk);
            r = $random(seed);
            rx <= '{enable: r[0] | r[1], sync: r[2] | r[3], slot: r[4],
                    bitErr: r[5] & r[6], dataBit: r[7]};
        end
    endtask

    // One-cycle command pulse with the line quiet
    task automatic fire(input int i);
        @(posedge clk);
        cmd[i] <= 1'b1;
        rx.slot <= 1'b0;
        rx.bitErr <= 1'b0;
        @(posedge clk);
        cmd <= '0;
    endtask

    // Command pulse on a busy slot: with a results capture the event lands in the new interval
    task automatic fireBusy(input int i);
        @(posedge clk);
        cmd[i] <= 1'b1;
        rx <= '{enable: 1'b1, sync: 1'b1, slot: 1'b1, bitErr: 1'b1, dataBit: 1'b1};
        @(posedge clk);
        cmd <= '0;
        rx <= '0;
    endtask

    task automatic read32(input logic [9:0] lo, input logic [9:0] hi, output logic [31:0] v);
        host.read(hi, v[31:16]);
        host.read(lo, v[15:0]);
    endtask

    task automatic checkAll();
        logic [31:0] v;
        read32(bert_rx_pkg::BIT_COUNT_LOW_OFS, bert_rx_pkg::BIT_COUNT_HIGH_OFS, v);
        chk("bit_count", eBitFg, v);
        read32(bert_rx_pkg::PATTERN_CAPT_LOW_OFS, bert_rx_pkg::PATTERN_CAPT_HIGH_OFS, v);
        chk("pattern_capture", ePat, v);
        read32(bert_rx_pkg::ERROR_COUNT_LOW_OFS, bert_rx_pkg::ERROR_COUNT_HIGH_OFS, v);
        chk("error_count", eErrFg, v);
    endtask

    // ------------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------------
    initial begin
        logic [15:0] d;
        repeat (16) @(posedge clk);
        rst <= 1'b0;
        // Reset values, plus a neighbouring unmapped address
        checkAll();
        host.read(10'h2B0, d);
        chk("unmapped", 32'h0, {16'h0, d});
        fixMode <= 1'b1;
        eie <= 1'b1;
        bie <= 1'b1;
        for (int k = 0; k < 6; k++) begin
            traffic(300);
            fire(0);
            traffic(80);
            // Second interval end while results unread must be refused
            fire(0);
            if (k[0]) fireBusy(1);
            gen <= $random(seed);
            patLen <= 5'($random(seed));
            fixMode <= (k != 3);
            fire(2);
            checkAll();
            bie <= k[1];
            eie <= ~k[0];
            fireBusy(3);
        end
        // Capture command overriding an unread result
        traffic(50);
        fire(0);
        traffic(20);
        // Error read in the transfer cycle: the set of the flag must win
        fork
            host.read(bert_rx_pkg::ERROR_COUNT_LOW_OFS, d);
            fire(1);
        join
        checkAll();
        test_done();
    end

    // Guard against a hang
    initial begin
        repeat (100000) @(posedge clk);
        n_errors++;
        test_done();
    end
endmodule

`default_nettype wire
